/* File: dv/cih_seq_model.sv */
`timescale 1ns/1ps
`default_nettype none

// instruction stream: one completion every LEN cycles, counter held at zero during a call
module cih_seq_model #(
  parameter int LEN = 3
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic long_call_i,
  input  wire logic ret_req_i,
  output logic      instr_done_o,
  output logic      return_from_interrupt_o
);
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;

  always_comb
  begin
    cnt_nxt = (cnt_r == 4'(LEN - 1)) ? 4'h0 : cnt_r + 4'h1;
    if (long_call_i)
    begin
      cnt_nxt = 4'h0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    cnt_r <= rst_i ? 4'h0 : cnt_nxt;
  end

  assign instr_done_o = !long_call_i && (cnt_r == 4'(LEN - 1));
  // return qualifies the next completion only when the routine asks for it
  assign return_from_interrupt_o       = instr_done_o && ret_req_i;
endmodule : cih_seq_model

`default_nettype wire

/* File: dv/test_cpu_interrupt_handler.sv */
`timescale 1ns/1ps
`default_nettype none

module test_cpu_interrupt_handler;
  logic        clk_i;
  logic        rst_i;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [31:0] wdat;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [11:0] src;
  logic        instr_done;
  logic        return_from_interrupt;
  logic        ret_req;
  logic        long_call_o;
  logic [15:0] vector_o;
  logic        irq_o;
  logic [31:0] rd;
  int          error_cnt;
  int          checks_done;

  cih_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'h1), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .ext_pin_irq_zero_i(src[0]), .timer0_overflow_i(src[1]), .ext_pin_irq_one_i(src[2]),
    .timer1_overflow_i(src[3]), .uart_receive_flag_i(src[4]), .uart_transmit_flag_i(src[5]),
    .timer2_low_overflow_flag_i(src[6]), .timer2_high_overflow_flag_i(src[7]),
    .spi_transfer_done_flag_i(src[8]), .spi_write_collision_flag_i(src[9]),
    .spi_mode_fault_flag_i(src[10]), .spi_receive_overrun_flag_i(src[11]),
    .instr_done_i(instr_done), .return_from_interrupt_i(return_from_interrupt), .long_call_o(long_call_o),
    .vector_o(vector_o), .irq_o(irq_o));

  cih_seq_model seq (.clk_i(clk_i), .rst_i(rst_i), .long_call_i(long_call_o),
    .ret_req_i(ret_req), .instr_done_o(instr_done), .return_from_interrupt_o(return_from_interrupt));

  initial
  begin
    clk_i = 1'h0;
    forever #4 clk_i = ~clk_i;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      error_cnt++;
    end
  endtask : chk

  task automatic bail(input string nm);
    $display("[FAIL] %s expected response seen timeout", nm);
    error_cnt++;
    finish_test();
  endtask : bail

  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= {24'h000000, d};
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'h1 && n < 40);
    rd = wb_dat_o;
    cyc <= 1'h0;
    stb <= 1'h0;
    if (n >= 40) bail("wb_ack");
  endtask : wb

  // waits for a call, checks its vector and that it lasts four cycles
  task automatic call_chk(input string nm, input logic [15:0] v);
    int n;
    n = 0;
    while (long_call_o !== 1'h1 && n < 80)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 80) bail(nm);
    chk(nm, {16'h0000, vector_o}, {16'h0000, v});
    n = 0;
    while (long_call_o === 1'h1 && n < 10)
    begin
      n++;
      @(posedge clk_i);
    end
    chk("call_len", 32'(n), 32'h4);
  endtask : call_chk

  task automatic do_ret();
    int n;
    n = 0;
    ret_req <= 1'h1;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (return_from_interrupt !== 1'h1 && n < 40);
    ret_req <= 1'h0;
    if (n >= 40) bail("return_from_interrupt");
  endtask : do_ret

  function automatic logic [15:0] vec(input int k);
    int o;
    o = (k < 4) ? k : (k < 6) ? 4 : (k < 8) ? 5 : 6;
    return 16'h0003 + 16'(8 * o);
  endfunction : vec

  task automatic t_regs();
    wb(1'h0, cih_pkg::ADR_ENABLE, 8'h00);
    chk("enable_rst", rd, 32'h00000000);
    wb(1'h0, cih_pkg::ADR_PRIORITY, 8'h00);
    chk("priority_rst", rd, 32'h00000080);
    wb(1'h1, cih_pkg::ADR_PRIORITY, 8'h7F);
    wb(1'h0, cih_pkg::ADR_PRIORITY, 8'h00);
    chk("priority_rw", rd, 32'h000000FF);
    wb(1'h1, cih_pkg::ADR_PRIORITY, 8'h00);
    wb(1'h0, cih_pkg::ADR_PRIORITY, 8'h00);
    chk("priority_b7", rd, 32'h00000080);
    wb(1'h0, 8'h10, 8'h00);
    chk("unmapped", rd, 32'h00000000);
    $display("test regs done");
  endtask : t_regs

  task automatic t_vectors();
    wb(1'h1, cih_pkg::ADR_ENABLE, 8'hFF);
    for (int k = 0; k < 12; k++)
    begin
      src[k] <= 1'h1;
      if (k < 4)
      begin
        @(posedge clk_i);
        src[k] <= 1'h0;
      end
      call_chk("vector", vec(k));
      // software clear of peripheral-owned flags
      src[k] <= 1'h0;
      do_ret();
      wb(1'h0, cih_pkg::ADR_PENDING, 8'h00);
      if (k < 4) chk("hw_clear", 32'(rd[k]), 32'h0);
    end
    $display("test vectors done");
  endtask : t_vectors

  task automatic t_gate();
    int n;
    n = 0;
    wb(1'h1, cih_pkg::ADR_ENABLE, 8'h7F);
    src[4] <= 1'h1;
    repeat (20)
    begin
      @(posedge clk_i);
      n += int'(long_call_o === 1'h1);
    end
    chk("gated", 32'(n), 32'h0);
    wb(1'h1, cih_pkg::ADR_ENABLE, 8'hFF);
    call_chk("ungated", 16'h0023);
    src[4] <= 1'h0;
    do_ret();
    $display("test gate done");
  endtask : t_gate

  task automatic t_prio();
    wb(1'h1, cih_pkg::ADR_PRIORITY, 8'h40);
    src[0] <= 1'h1;
    src[8] <= 1'h1;
    @(posedge clk_i);
    src[0] <= 1'h0;
    call_chk("high_first", 16'h0033);
    src[8] <= 1'h0;
    do_ret();
    call_chk("low_after", 16'h0003);
    do_ret();
    // low routine preempted by a high request
    src[1] <= 1'h1;
    @(posedge clk_i);
    src[1] <= 1'h0;
    call_chk("low_entry", 16'h000B);
    src[8] <= 1'h1;
    call_chk("preempt", 16'h0033);
    wb(1'h0, cih_pkg::ADR_SERVICE, 8'h00);
    chk("service", rd, 32'h00000003);
    wb(1'h0, cih_pkg::ADR_STATUS, 8'h00);
    chk("nest", 32'(rd[2]), 32'h1);
    src[8] <= 1'h0;
    do_ret();
    @(posedge clk_i);
    do_ret();
    wb(1'h1, cih_pkg::ADR_PRIORITY, 8'h00);
    src[1] <= 1'h1;
    src[2] <= 1'h1;
    @(posedge clk_i);
    src[1] <= 1'h0;
    src[2] <= 1'h0;
    call_chk("tie_order", 16'h000B);
    do_ret();
    call_chk("tie_next", 16'h0013);
    do_ret();
    $display("test prio done");
  endtask : t_prio

  task automatic t_return_from_interrupt();
    int n;
    int done_cnt;
    n = 0;
    done_cnt = 0;
    wb(1'h1, cih_pkg::ADR_MASK, 8'h01);
    // clear stale status bits first
    wb(1'h0, cih_pkg::ADR_STATUS, 8'h00);
    src[5] <= 1'h1;
    call_chk("first", 16'h0023);
    chk("irq", 32'(irq_o), 32'h1);
    do_ret();
    // completions after the return, up to the re-entry call
    do
    begin
      @(posedge clk_i);
      n++;
      done_cnt += int'(instr_done === 1'h1);
    end
    while (long_call_o !== 1'h1 && n < 40);
    if (n >= 40) bail("one_instr");
    chk("one_instr", 32'(done_cnt), 32'h1);
    call_chk("rerequest", 16'h0023);
    src[5] <= 1'h0;
    do_ret();
    wb(1'h0, cih_pkg::ADR_STATUS, 8'h00);
    chk("status_call", 32'(rd[0]), 32'h1);
    @(posedge clk_i);
    chk("irq_clear", 32'(irq_o), 32'h0);
    $display("test return_from_interrupt done");
  endtask : t_return_from_interrupt

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  initial
  begin
    error_cnt = 0;
    checks_done = 0;
    rst_i = 1'h1;
    cyc = 1'h0;
    stb = 1'h0;
    we = 1'h0;
    adr = 8'h00;
    wdat = 32'h00000000;
    src = 12'h000;
    ret_req = 1'h0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    t_regs();
    t_vectors();
    t_gate();
    t_prio();
    t_return_from_interrupt();
    finish_test();
  end
endmodule : test_cpu_interrupt_handler

`default_nettype wire

/* File: hw/cih_pkg.sv */
package cih_pkg;

  // register byte addresses
  localparam logic [7:0] ADR_ENABLE   = 8'hA8;
  localparam logic [7:0] ADR_PRIORITY = 8'hB8;
  localparam logic [7:0] ADR_PENDING  = 8'hC0;
  localparam logic [7:0] ADR_STATUS   = 8'hC4;
  localparam logic [7:0] ADR_MASK     = 8'hC8;
  localparam logic [7:0] ADR_SERVICE  = 8'hCC;

  // reset values
  localparam logic [7:0] ENABLE_RST   = 8'h00;
  localparam logic [7:0] PRIORITY_RST = 8'h80;
  localparam logic [2:0] STATUS_RST   = 3'h0;
  localparam logic [2:0] MASK_RST     = 3'h0;

  // enable / priority field positions; bit index equals fixed order
  localparam int GLOBAL_EN_BIT = 7;
  localparam int PRIO_FIXED_BIT = 7;
  localparam int NUM_SRC       = 7;
  localparam int NUM_LOCAL     = 4;
  localparam int SRC_PIN0      = 0;
  localparam int SRC_TIMER0    = 1;
  localparam int SRC_PIN1      = 2;
  localparam int SRC_TIMER1    = 3;
  localparam int SRC_UART      = 4;
  localparam int SRC_TIMER2    = 5;
  localparam int SRC_SPI       = 6;

  // service vectors, indexed by fixed order
  localparam logic [6:0][15:0] VECTORS = {16'h0033, 16'h002B, 16'h0023, 16'h001B,
                                          16'h0013, 16'h000B, 16'h0003};

  // status bit positions
  localparam int STS_CALL  = 0;
  localparam int STS_RETURN_FROM_INTERRUPT  = 1;
  localparam int STS_NEST  = 2;
  localparam int STS_W     = 3;

  // service register field positions
  localparam int SVC_ACT_LO = 0;
  localparam int SVC_ACT_HI = 1;

  // timing counts, in system clock cycles
  localparam logic [2:0] LONG_CALL_CYCLES  = 3'h4;
  localparam int         DETECT_CYCLES = 1;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_CALL = 2'b10
  } cih_state_e;

endpackage : cih_pkg

/* File: hw/cih_top.sv */
// Contract
// - Every cycle all pending requests are sampled and priority decoded.
// - The fastest response is one detect cycle plus a four-cycle long call.
// - A request pending at a return from interrupt waits for one more instruction.
// - Worst case without blocking is detect, return, a divide, then the call.
// - A request waits while a routine of equal or higher level is in service.
// - Pin 0 vectors to 0x0003 order 0, pin 1 to 0x0013 order 2, flags cleared on vectoring.
// - Timer 0 overflow vectors to 0x000B order 1 and its flag is cleared on vectoring.
// - Timer 1 overflow vectors to 0x001B order 3 and its flag is cleared on vectoring.
// - Timer 2 low or high overflow requests 0x002B order 5 and software clears them.
// - UART receive or transmit requests 0x0023 order 4 and software clears them.
// - Any of the four SPI flags requests 0x0033 order 6 and software clears them.
// - The global enable bit gates every source on top of its own enable bit.
// - Each priority bit puts its source at high level when 1, low when 0.
// - Priority bit 7 always reads 1 and ignores writes.
// - Low routines may be preempted by high requests; ties go by fixed order.
// - Flags set on their condition regardless of enables and re-request after return.
//
// Our own choice: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none

module cih_top (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        ext_pin_irq_zero_i,
  input  wire logic        ext_pin_irq_one_i,
  input  wire logic        timer0_overflow_i,
  input  wire logic        timer1_overflow_i,
  input  wire logic        timer2_low_overflow_flag_i,
  input  wire logic        timer2_high_overflow_flag_i,
  input  wire logic        uart_receive_flag_i,
  input  wire logic        uart_transmit_flag_i,
  input  wire logic        spi_transfer_done_flag_i,
  input  wire logic        spi_write_collision_flag_i,
  input  wire logic        spi_mode_fault_flag_i,
  input  wire logic        spi_receive_overrun_flag_i,
  input  wire logic        instr_done_i,
  input  wire logic        return_from_interrupt_i,
  output logic             long_call_o,
  output logic      [15:0] vector_o,
  output logic             irq_o
);

  // lowest set index wins within one level
  function automatic logic [2:0] first_set(input logic [6:0] v);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = cih_pkg::NUM_SRC - 1; i >= 0; i--)
    begin
      if (v[i])
      begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction : first_set

  logic                 bus_req;
  logic                 wr_fire;
  logic                 rd_fire;
  logic                 ack_r;
  logic                 ack_nxt;
  logic [31:0]          rdat_r;
  logic [31:0]          rdat_nxt;
  logic [7:0]           enable_r;
  logic [7:0]           enable_nxt;
  logic [6:0]           prio_r;
  logic [6:0]           prio_nxt;
  logic [2:0]           status_r;
  logic [2:0]           status_nxt;
  logic [2:0]           mask_r;
  logic [2:0]           mask_nxt;
  logic [3:0]           flags_r;
  logic [3:0]           flags_nxt;
  logic [3:0]           flag_events;
  logic [6:0]           pending;
  logic [6:0]           req_vec;
  logic [6:0]           req_hi_r;
  logic [6:0]           req_lo_r;
  logic                 act_hi_r;
  logic                 act_hi_nxt;
  logic                 act_lo_r;
  logic                 act_lo_nxt;
  logic                 hi_ok;
  logic                 lo_ok;
  logic                 win_valid;
  logic                 win_hi;
  logic [2:0]           win_idx;
  logic                 take;
  logic                 return_from_interrupt_done;
  cih_pkg::cih_state_e  state_r;
  cih_pkg::cih_state_e  state_nxt;
  logic [2:0]           cnt_r;
  logic [2:0]           cnt_nxt;
  logic [15:0]          vector_r;
  logic [15:0]          vector_nxt;

  assign bus_req = wb_cyc_i && wb_stb_i;
  // writes and read-clears act on the edge where the master sees ack
  assign wr_fire = bus_req && ack_r && wb_we_i && wb_sel_i[0];
  assign rd_fire = bus_req && ack_r && !wb_we_i;
  assign ack_nxt = bus_req && !ack_r;

  assign flag_events = {timer1_overflow_i, ext_pin_irq_one_i,
                        timer0_overflow_i, ext_pin_irq_zero_i};

  assign pending = {spi_transfer_done_flag_i | spi_write_collision_flag_i |
                    spi_mode_fault_flag_i | spi_receive_overrun_flag_i,
                    timer2_low_overflow_flag_i | timer2_high_overflow_flag_i,
                    uart_receive_flag_i | uart_transmit_flag_i,
                    flags_r};

  assign req_vec = pending & enable_r[6:0] & {7{enable_r[cih_pkg::GLOBAL_EN_BIT]}};

  assign hi_ok     = |req_hi_r && !act_hi_r;
  assign lo_ok     = |req_lo_r && !act_hi_r && !act_lo_r;
  assign win_valid = hi_ok || lo_ok;
  assign win_hi    = hi_ok;
  assign win_idx   = hi_ok ? first_set(req_hi_r) : first_set(req_lo_r);
  assign return_from_interrupt_done = instr_done_i && return_from_interrupt_i;

  // no call at the return's own completion
  assign take = (state_r == cih_pkg::ST_IDLE) && instr_done_i &&
                !return_from_interrupt_i && win_valid;

  always_comb
  begin
    flags_nxt = flags_r;
    if (wr_fire && wb_adr_i == cih_pkg::ADR_PENDING)
    begin
      flags_nxt = wb_dat_i[3:0];
    end
    if (take && !win_idx[2])
    begin
      flags_nxt[win_idx[1:0]] = 1'b0;
    end
    flags_nxt = flags_nxt | flag_events;
  end

  always_comb
  begin
    enable_nxt = enable_r;
    prio_nxt   = prio_r;
    mask_nxt   = mask_r;
    if (wr_fire)
    begin
      case (wb_adr_i)
        cih_pkg::ADR_ENABLE:   enable_nxt = wb_dat_i[7:0];
        cih_pkg::ADR_PRIORITY: prio_nxt   = wb_dat_i[6:0];
        cih_pkg::ADR_MASK:     mask_nxt   = wb_dat_i[2:0];
        default:               mask_nxt   = mask_r;
      endcase
    end
  end

  always_comb
  begin
    status_nxt = status_r;
    if (rd_fire && wb_adr_i == cih_pkg::ADR_STATUS)
    begin
      status_nxt = status_r & ~rdat_r[2:0];
    end
    status_nxt[cih_pkg::STS_CALL] = status_nxt[cih_pkg::STS_CALL] | take;
    status_nxt[cih_pkg::STS_RETURN_FROM_INTERRUPT] = status_nxt[cih_pkg::STS_RETURN_FROM_INTERRUPT] | return_from_interrupt_done;
    status_nxt[cih_pkg::STS_NEST] = status_nxt[cih_pkg::STS_NEST] | (take && act_lo_r);
  end

  always_comb
  begin
    rdat_nxt = 32'h0000_0000;
    if (ack_nxt)
    begin
      case (wb_adr_i)
        cih_pkg::ADR_ENABLE:   rdat_nxt[7:0] = enable_r;
        cih_pkg::ADR_PRIORITY: rdat_nxt[7:0] = {1'b1, prio_r};
        cih_pkg::ADR_PENDING:  rdat_nxt[6:0] = pending;
        cih_pkg::ADR_STATUS:   rdat_nxt[2:0] = status_r;
        cih_pkg::ADR_MASK:     rdat_nxt[2:0] = mask_r;
        cih_pkg::ADR_SERVICE:  rdat_nxt[1:0] = {act_hi_r, act_lo_r};
        default:               rdat_nxt      = 32'h0000_0000;
      endcase
    end
  end

  always_comb
  begin
    state_nxt  = state_r;
    cnt_nxt    = cnt_r;
    vector_nxt = vector_r;
    act_hi_nxt = act_hi_r;
    act_lo_nxt = act_lo_r;
    case (state_r)
      cih_pkg::ST_IDLE:
      begin
        if (take)
        begin
          state_nxt  = cih_pkg::ST_CALL;
          cnt_nxt    = cih_pkg::LONG_CALL_CYCLES - 3'h1;
          vector_nxt = cih_pkg::VECTORS[win_idx];
          act_hi_nxt = act_hi_r | win_hi;
          act_lo_nxt = act_lo_r | !win_hi;
        end
        else if (return_from_interrupt_done)
        begin
          act_hi_nxt = 1'b0;
          act_lo_nxt = act_lo_r && !act_hi_r ? 1'b0 : act_lo_r;
        end
      end
      cih_pkg::ST_CALL:
      begin
        cnt_nxt = cnt_r - 3'h1;
        if (cnt_r == 3'h0)
        begin
          state_nxt = cih_pkg::ST_IDLE;
        end
      end
      default:
      begin
        state_nxt = cih_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_r    <= 1'b0;
      rdat_r   <= 32'h0000_0000;
      enable_r <= cih_pkg::ENABLE_RST;
      prio_r   <= cih_pkg::PRIORITY_RST[6:0];
      status_r <= cih_pkg::STATUS_RST;
      mask_r   <= cih_pkg::MASK_RST;
      flags_r  <= 4'h0;
      req_hi_r <= 7'h00;
      req_lo_r <= 7'h00;
      state_r  <= cih_pkg::ST_IDLE;
      cnt_r    <= 3'h0;
      vector_r <= 16'h0000;
      act_hi_r <= 1'b0;
      act_lo_r <= 1'b0;
    end
    else
    begin
      ack_r    <= ack_nxt;
      rdat_r   <= rdat_nxt;
      enable_r <= enable_nxt;
      prio_r   <= prio_nxt;
      status_r <= status_nxt;
      mask_r   <= mask_nxt;
      flags_r  <= flags_nxt;
      req_hi_r <= req_vec & prio_r;
      req_lo_r <= req_vec & ~prio_r;
      state_r  <= state_nxt;
      cnt_r    <= cnt_nxt;
      vector_r <= vector_nxt;
      act_hi_r <= act_hi_nxt;
      act_lo_r <= act_lo_nxt;
    end
  end

  assign wb_ack_o    = ack_r;
  assign wb_dat_o    = rdat_r;
  assign long_call_o = (state_r == cih_pkg::ST_CALL);
  assign vector_o    = vector_r;
  assign irq_o       = |(status_r & mask_r);

  property p_detect;
    @(posedge clk_i) disable iff (rst_i)
    (|req_vec) |=> (|{req_hi_r, req_lo_r});
  endproperty
  a_detect: assert property (p_detect) else $error("request not sampled");

  property p_call_len;
    @(posedge clk_i) disable iff (rst_i)
    take |=> long_call_o [*4] ##1 !long_call_o;
  endproperty
  a_call_len: assert property (p_call_len) else $error("long call length wrong");

  property p_return_from_interrupt_gap;
    @(posedge clk_i) disable iff (rst_i)
    return_from_interrupt_done |-> !take ##1 !long_call_o;
  endproperty
  a_return_from_interrupt_gap: assert property (p_return_from_interrupt_gap) else $error("call at return");

  property p_global;
    @(posedge clk_i) disable iff (rst_i)
    !enable_r[cih_pkg::GLOBAL_EN_BIT] |=> !take;
  endproperty
  a_global: assert property (p_global) else $error("call with global off");

  property p_prio_bit;
    @(posedge clk_i) disable iff (rst_i)
    (ack_r && !wb_we_i && wb_adr_i == cih_pkg::ADR_PRIORITY) |-> wb_dat_o[7];
  endproperty
  a_prio_bit: assert property (p_prio_bit) else $error("priority bit 7 not one");

  property p_no_preempt;
    @(posedge clk_i) disable iff (rst_i)
    (act_hi_r || (act_lo_r && !(|req_hi_r))) |-> !take;
  endproperty
  a_no_preempt: assert property (p_no_preempt) else $error("illegal preemption");

  property p_hw_clear;
    @(posedge clk_i) disable iff (rst_i)
    (take && !win_idx[2] && !flag_events[win_idx[1:0]]) |=> !flags_r[$past(win_idx[1:0])];
  endproperty
  a_hw_clear: assert property (p_hw_clear) else $error("flag not cleared");

  property p_vector;
    @(posedge clk_i) disable iff (rst_i)
    take |=> vector_o == cih_pkg::VECTORS[$past(win_idx)];
  endproperty
  a_vector: assert property (p_vector) else $error("wrong vector");

  property p_flag_set;
    @(posedge clk_i) disable iff (rst_i)
    ext_pin_irq_zero_i |=> flags_r[cih_pkg::SRC_PIN0];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set");

endmodule : cih_top

`default_nettype wire
